// *** include/tdt_pkg.sv ***
package tdt_pkg;

   // ==========================================================
   // Register word indices (byte address is four times index)
   // ==========================================================
   localparam logic [11:0] IDX_FLAGS     = 12'h000;
   localparam logic [11:0] IDX_THRESH    = 12'h003;
   localparam logic [11:0] IDX_LEVELS    = 12'h026;
   localparam logic [11:0] IDX_LEVELS_HI = 12'h035;
   localparam logic [11:0] IDX_ON_POINT  = 12'h051;
   localparam logic [11:0] IDX_OFF_POINT = 12'h052;
   // Block-local registers
   localparam logic [11:0] IDX_CONFIG    = 12'h100;
   localparam logic [11:0] IDX_BAND      = 12'h101;
   localparam logic [11:0] IDX_IRQ_STAT  = 12'h102;
   localparam logic [11:0] IDX_IRQ_MASK  = 12'h103;

   // ==========================================================
   // Fields and encodings
   // ==========================================================
   localparam int          MODE_W        = 7;
   localparam logic [6:0]  MODE_STANDBY  = 7'h00;
   localparam logic [6:0]  MODE_DETECT   = 7'h02;
   localparam int          BAND_A_BIT    = 15;
   localparam int          BAND_B_BIT    = 14;
   localparam int          CHAIN_BIT     = 13;
   localparam int          NUM_DET       = 16;

   // ==========================================================
   // Default thresholds, 32767 * 10^(dBm/20)
   // ==========================================================
   localparam logic [15:0] DEF_THRESH    = 16'h0822;  // -24 dBm, 2082
   localparam logic [15:0] DEF_ON_POINT  = 16'h0245;  // -35 dBm, 581
   localparam logic [15:0] DEF_OFF_POINT = 16'h0105;  // -42 dBm, 261
   // Arbitrary identification value
   localparam logic [15:0] PART_ID       = 16'hA5C3;

   // IRQ status bit positions
   localparam int          IRQ_DISC      = 0;
   localparam int          IRQ_BAND_A    = 1;
   localparam int          IRQ_BAND_B    = 2;
   localparam int          IRQ_W         = 3;

endpackage : tdt_pkg

// *** hw/tdt_thresholds.sv ***
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// R1: A band detector flag clears when its measured power falls below the OFF point.
// R2: A band detector flag sets when its measured power rises above the ON point.
// R3: Writing mode 2 reloads the OFF point with its default.
// R4: Writing mode 2 reloads the ON point with its default.
// R5: Host encodes thresholds as 32767 times ten to the dBm over 20.
// R6: In detect mode each of the sixteen measured levels shows in its own word.
// R7: Host may compare levels to find the dominant tone.
// R8: One shared threshold; each discrete flag is set above it and cleared below.
// R9: Selecting detect mode overwrites the shared threshold with its default.
// R10: Host writes a custom shared threshold only after selecting detect mode.
// R11: In detect mode discrete detector n reports in bit n of the flags word.
// R12: Host trusts the discrete flags word only in detect mode.
// R13: Standby or reset writes the part identification into the flags word.
// R14: Band flags are bits 15 and 14; with chaining only bit 15 carries the result.
// R15: Thresholds, levels and flags are 16-bit readable words; thresholds are writable.
module tdt_thresholds
   import tdt_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [13:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [255:0] disc_level_in,
   input  wire logic [15:0] band_a_power,
   input  wire logic [15:0] band_b_power,
   input  wire logic [15:0] chain_power,
   output logic             irq
);

   // ==========================================================
   // State
   // ==========================================================
   logic [6:0]         mode_r,   mode_nxt;
   logic               chain_r,  chain_nxt;
   logic [15:0]        thresh_r, thresh_nxt;
   logic [15:0]        on_r,     on_nxt;
   logic [15:0]        off_r,    off_nxt;
   logic [15:0]        flags_r,  flags_nxt;
   logic               band_a_r, band_a_nxt;
   logic               band_b_r, band_b_nxt;
   logic [15:0]        lev_r [NUM_DET];
   logic [15:0]        lev_nxt [NUM_DET];
   logic [IRQ_W-1:0]   ist_r,    ist_nxt;
   logic [IRQ_W-1:0]   imask_r,  imask_nxt;
   logic [31:0]        rdata_r,  rdata_nxt;

   logic        acc;
   logic        wr;
   logic        rd;
   logic [11:0] idx;
   logic        mapped;
   logic [15:0] disc_hit;
   logic [15:0] band_word;
   logic [IRQ_W-1:0] ev;
   logic        sel_detect;
   logic        sel_standby;

   // Hysteresis step shared by every band detector
   function automatic logic hyst(input logic cur, input logic [15:0] pwr,
                                 input logic [15:0] onp, input logic [15:0] offp);
      logic r;
      r = cur;
      // R2: above ON point sets
      if (pwr > onp) begin
         r = 1'b1;
      end
      // R1: below OFF point clears
      else if (pwr < offp) begin
         r = 1'b0;
      end
      return r;
   endfunction : hyst

   // Config write that selects one given mode
   function automatic logic mode_wr(input logic        w,
                                    input logic [11:0] i,
                                    input logic [6:0]  d,
                                    input logic [6:0]  m);
      return w && (i == IDX_CONFIG) && (d == m);
   endfunction : mode_wr

   // Word index falls inside the level block
   function automatic logic in_levels(input logic [11:0] i);
      return (i >= IDX_LEVELS) && (i <= IDX_LEVELS_HI);
   endfunction : in_levels

   // ==========================================================
   // APB decode; always ready, no wait states
   // ==========================================================
   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign rd      = acc & ~pwrite;
   assign idx     = paddr[13:2];
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata  = rdata_r;
   assign irq     = |(ist_r & imask_r);

   // Address map check
   always_comb begin
      mapped = (idx == IDX_FLAGS) || (idx == IDX_THRESH) || (idx == IDX_ON_POINT) ||
               (idx == IDX_OFF_POINT) || (idx == IDX_CONFIG) || (idx == IDX_BAND) ||
               (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK) ||
               in_levels(idx);
   end

   // Discrete detector comparisons and band flags word
   always_comb begin
      for (int i = 0; i < NUM_DET; i++) begin
         // R8: shared threshold compare
         disc_hit[i] = disc_level_in[i*16 +: 16] > thresh_r;
      end
      band_word = '0;
      // R14: band flags in bits 15 and 14
      band_word[BAND_A_BIT] = band_a_r;
      band_word[BAND_B_BIT] = chain_r ? 1'b0 : band_b_r;
      band_word[CHAIN_BIT]  = chain_r;
   end

   // ==========================================================
   // Configuration and thresholds
   // ==========================================================
   // Mode select strobes, decoded once for both state groups
   assign sel_detect  = mode_wr(wr, idx, pwdata[MODE_W-1:0], MODE_DETECT);
   assign sel_standby = mode_wr(wr, idx, pwdata[MODE_W-1:0], MODE_STANDBY);

   // Host writes; defaults reload on the very edge of the mode write, so a
   // custom threshold only survives if written after the mode change
   always_comb begin
      mode_nxt   = mode_r;
      chain_nxt  = chain_r;
      thresh_nxt = thresh_r;
      on_nxt     = on_r;
      off_nxt    = off_r;
      imask_nxt  = imask_r;
      // R15: writable words
      if (wr) begin
         unique case (idx)
            IDX_THRESH:    thresh_nxt = pwdata[15:0];
            IDX_ON_POINT:  on_nxt     = pwdata[15:0];
            IDX_OFF_POINT: off_nxt    = pwdata[15:0];
            IDX_BAND:      chain_nxt  = pwdata[CHAIN_BIT];
            IDX_IRQ_MASK:  imask_nxt  = pwdata[IRQ_W-1:0];
            IDX_CONFIG:    mode_nxt   = pwdata[MODE_W-1:0];
            default: ;
         endcase
      end
      // R9: shared threshold default
      if (sel_detect) begin
         thresh_nxt = DEF_THRESH;
      end
      // R4: ON point default
      if (sel_detect) begin
         on_nxt = DEF_ON_POINT;
      end
      // R3: OFF point default
      if (sel_detect) begin
         off_nxt = DEF_OFF_POINT;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_r   <= MODE_STANDBY;
         chain_r  <= 1'b0;
         thresh_r <= DEF_THRESH;
         on_r     <= DEF_ON_POINT;
         off_r    <= DEF_OFF_POINT;
         imask_r  <= '0;
      end
      else begin
         mode_r   <= mode_nxt;
         chain_r  <= chain_nxt;
         thresh_r <= thresh_nxt;
         on_r     <= on_nxt;
         off_r    <= off_nxt;
         imask_r  <= imask_nxt;
      end
   end

   // ==========================================================
   // Detection
   // ==========================================================
   // Outside detect mode levels and band flags hold; the discrete flags hold too
   // until a standby write replaces them with the identification
   always_comb begin
      flags_nxt  = flags_r;
      band_a_nxt = band_a_r;
      band_b_nxt = band_b_r;
      lev_nxt    = lev_r;
      ev         = '0;
      if (mode_r == MODE_DETECT) begin
         // R11: detector n in bit n
         flags_nxt = disc_hit;
         // R6: levels captured per detector
         for (int i = 0; i < NUM_DET; i++) begin
            lev_nxt[i] = disc_level_in[i*16 +: 16];
         end
         // R14: chaining feeds detector A
         band_a_nxt = hyst(band_a_r, chain_r ? chain_power : band_a_power, on_r, off_r);
         band_b_nxt = chain_r ? 1'b0 : hyst(band_b_r, band_b_power, on_r, off_r);
         ev[IRQ_DISC]   = (disc_hit != flags_r);
         ev[IRQ_BAND_A] = band_a_nxt & ~band_a_r;
         ev[IRQ_BAND_B] = band_b_nxt & ~band_b_r;
      end
      // R13: identification on standby
      if (sel_standby) begin
         flags_nxt = PART_ID;
      end
   end

   // Detection registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // R13: identification after reset
         flags_r  <= PART_ID;
         band_a_r <= 1'b0;
         band_b_r <= 1'b0;
         for (int i = 0; i < NUM_DET; i++) begin
            lev_r[i] <= '0;
         end
      end
      else begin
         flags_r  <= flags_nxt;
         band_a_r <= band_a_nxt;
         band_b_r <= band_b_nxt;
         lev_r    <= lev_nxt;
      end
   end

   // ==========================================================
   // Interrupt status
   // ==========================================================
   // A read clears only the bits its setup cycle reported, so an event
   // landing between setup and access is not lost; set wins over clear
   always_comb begin
      ist_nxt = ist_r;
      if (rd && (idx == IDX_IRQ_STAT)) begin
         ist_nxt = ist_r & ~rdata_r[IRQ_W-1:0];
      end
      ist_nxt = ist_nxt | ev;
   end

   // Status register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ist_r <= '0;
      end
      else begin
         ist_r <= ist_nxt;
      end
   end

   // ==========================================================
   // Read data
   // ==========================================================
   // Captured in the setup cycle; unmapped reads return zero
   always_comb begin
      rdata_nxt = '0;
      if (psel & ~penable & ~pwrite) begin
         if (in_levels(idx)) begin
            rdata_nxt[15:0] = lev_r[4'(idx - IDX_LEVELS)];
         end
         else begin
            unique case (idx)
               IDX_FLAGS:     rdata_nxt[15:0] = flags_r;
               IDX_THRESH:    rdata_nxt[15:0] = thresh_r;
               IDX_ON_POINT:  rdata_nxt[15:0] = on_r;
               IDX_OFF_POINT: rdata_nxt[15:0] = off_r;
               IDX_CONFIG:    rdata_nxt[MODE_W-1:0] = mode_r;
               IDX_BAND:      rdata_nxt[15:0] = band_word;
               IDX_IRQ_STAT:  rdata_nxt[IRQ_W-1:0] = ist_r;
               IDX_IRQ_MASK:  rdata_nxt[IRQ_W-1:0] = imask_r;
               default: ;
            endcase
         end
      end
   end

   // Read data register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_r <= '0;
      end
      else begin
         rdata_r <= rdata_nxt;
      end
   end

endmodule : tdt_thresholds

// *** verification/tdt_checker.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port checker for the threshold block
module tdt_checker
   import tdt_pkg::*;
(
   input logic        clk_sys,
   input logic        rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [13:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr
);
   logic [11:0] idx;
   logic        acc;
   logic        wrx;
   logic        rdx;
   logic        mapd;
   logic [3:0]  dflt_r;
   // Decoded access phase
   assign idx = paddr[13:2];
   assign acc = psel & penable;
   assign wrx = acc & pwrite;
   assign rdx = acc & ~pwrite;
   assign mapd = idx inside {IDX_FLAGS, IDX_THRESH, [IDX_LEVELS:IDX_LEVELS_HI], IDX_ON_POINT,
                             IDX_OFF_POINT, [IDX_CONFIG:IDX_IRQ_MASK]};
   // Words known at default: thresh, on, off, id; detect mode wipes host values
   always_ff @(posedge clk_sys) begin
      if (rst)
         dflt_r <= 4'hF;
      else if (wrx && idx == IDX_CONFIG && pwdata[6:0] == MODE_DETECT)
         dflt_r <= 4'hE;
      else if (wrx && idx == IDX_CONFIG && pwdata[6:0] == MODE_STANDBY)
         dflt_r[0] <= 1'b1;
      else if (wrx)
         dflt_r <= dflt_r & ~{idx == IDX_THRESH, idx == IDX_ON_POINT, idx == IDX_OFF_POINT, 1'b0};
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ready_in_access_a: assert property (acc |-> pready)
      else $error("pready low in access");
   unmapped_error_a: assert property (acc && !mapd |-> pslverr)
      else $error("no pslverr on unmapped word");
   unmapped_zero_a: assert property (rdx && !mapd |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   mapped_no_err_a: assert property (acc && mapd |-> !pslverr)
      else $error("pslverr on mapped word");
   err_only_access_a: assert property (!acc |-> !pslverr)
      else $error("pslverr outside access");
   upper_zero_a: assert property (prdata[31:16] == 16'h0000)
      else $error("read data upper half set");
   reset_rdata_a: assert property ($fell(rst) |-> prdata == 32'h0)
      else $error("read data not cleared by reset");
   thr_default_a: assert property (rdx && idx == IDX_THRESH && dflt_r[3]
      |-> prdata[15:0] == DEF_THRESH) else $error("shared threshold not default");
   on_default_a: assert property (rdx && idx == IDX_ON_POINT && dflt_r[2]
      |-> prdata[15:0] == DEF_ON_POINT) else $error("on point not default");
   off_default_a: assert property (rdx && idx == IDX_OFF_POINT && dflt_r[1]
      |-> prdata[15:0] == DEF_OFF_POINT) else $error("off point not default");
   part_id_a: assert property (rdx && idx == IDX_FLAGS && dflt_r[0]
      |-> prdata[15:0] == PART_ID) else $error("identity missing");
   flags_read_c: cover property (rdx && idx == IDX_FLAGS && !dflt_r[0]);
   detect_mode_c: cover property (wrx && idx == IDX_CONFIG && pwdata[6:0] == MODE_DETECT);
   unmapped_c: cover property (acc && !mapd);
endmodule : tdt_checker

// *** verification/tdt_thresholds_tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// Bench for the threshold block
module tdt_thresholds_tb
   import tdt_pkg::*;
;
   logic         clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, err, ea, eb;
   logic [13:0]  paddr;
   logic [31:0]  pwdata, prdata;
   logic [255:0] lv, nl;
   logic [15:0]  pa, pb, pc, rd, thr;
   logic [15:0]  sa [7] = '{16'h0201, 16'h0150, 16'h0200, 16'h0100, 16'h00FF, 16'h0150, 16'h0200};
   int           n_errors, samples_checked, k, r;
   tdt_thresholds dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .disc_level_in(lv), .band_a_power(pa), .band_b_power(pb),
      .chain_power(pc), .irq(irq));
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] i, input logic [15:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata[15:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t word %h expected %h", $time, g, e);
      end
   endtask : chk_w
   task automatic chk_b(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
      end
   endtask : chk_b
   // Expected discrete flags: strictly above threshold
   function automatic logic [15:0] exp_f(logic [255:0] l, logic [15:0] t);
      logic [15:0] f;
      for (int n = 0; n < 16; n++)
         f[n] = l[16*n+:16] > t;
      return f;
   endfunction : exp_f
   // Band hysteresis with on 0x0200, off 0x0100; between them the flag holds
   function automatic logic bnx(logic c, logic [15:0] p);
      return (p > 16'h0200) ? 1'b1 : (p < 16'h0100) ? 1'b0 : c;
   endfunction : bnx
   task test_done;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // Free-running 20 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Watchdog, far beyond the expected run of a few hundred cycles
   initial begin
      #1000000;
      n_errors++;
      test_done;
   end
   // Main sequence
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 46'h0};
      {lv, pa, pb, pc, ea, eb} = '0;
      n_errors = 0;
      samples_checked = 0;
      void'($urandom(34));
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b1, IDX_FLAGS, 16'h1234);
      apb(1'b0, IDX_FLAGS, 16'h0000);
      chk_w(rd, PART_ID);
      apb(1'b0, 12'h0FF, 16'h0000);
      chk_b(err, 1'b1);
      apb(1'b1, IDX_THRESH, 16'h1111);
      apb(1'b1, IDX_ON_POINT, 16'h1111);
      apb(1'b1, IDX_OFF_POINT, 16'h1111);
      apb(1'b1, IDX_CONFIG, {9'h000, MODE_DETECT});
      apb(1'b0, IDX_THRESH, 16'h0000);
      chk_w(rd, DEF_THRESH);
      apb(1'b0, IDX_ON_POINT, 16'h0000);
      chk_w(rd, DEF_ON_POINT);
      apb(1'b0, IDX_OFF_POINT, 16'h0000);
      chk_w(rd, DEF_OFF_POINT);
      thr = 16'($urandom_range(16'hF000, 16'h0100));
      apb(1'b1, IDX_THRESH, thr);
      apb(1'b0, IDX_THRESH, 16'h0000);
      chk_w(rd, thr);
      // Random levels, first pass pins the threshold boundary
      for (r = 0; r < 8; r++) begin
         for (k = 0; k < 16; k++)
            nl[16*k+:16] = 16'($urandom);
         if (r == 0)
            nl[47:0] = {thr - 16'h0001, thr + 16'h0001, thr};
         lv <= nl;
         repeat (2) @(posedge clk_sys);
         apb(1'b0, IDX_FLAGS, 16'h0000);
         chk_w(rd, exp_f(nl, thr));
         for (k = 0; k < 16 && r == 0; k++) begin
            apb(1'b0, IDX_LEVELS + 12'(k), 16'h0000);
            chk_w(rd, nl[16*k+:16]);
         end
      end
      apb(1'b1, IDX_ON_POINT, 16'h0200);
      apb(1'b1, IDX_OFF_POINT, 16'h0100);
      apb(1'b1, IDX_IRQ_MASK, 16'h0002);
      apb(1'b0, IDX_IRQ_STAT, 16'h0000);
      // Hysteresis walk; only band A rising is unmasked
      for (k = 0; k < 7; k++) begin
         pa <= sa[k];
         pb <= 16'($urandom_range(16'h0240, 16'h00C0));
         repeat (3) @(posedge clk_sys);
         chk_b(irq, bnx(ea, sa[k]) & ~ea);
         ea = bnx(ea, sa[k]);
         eb = bnx(eb, pb);
         apb(1'b0, IDX_IRQ_STAT, 16'h0000);
         apb(1'b0, IDX_BAND, 16'h0000);
         chk_b(rd[BAND_A_BIT], ea);
         chk_b(rd[BAND_B_BIT], eb);
      end
      apb(1'b1, IDX_BAND, 16'h2000);
      pc <= 16'h0300;
      repeat (3) @(posedge clk_sys);
      apb(1'b0, IDX_BAND, 16'h0000);
      chk_w(rd & 16'hC000, 16'h8000);
      // Discrete change interrupt, unmasked alone
      lv <= '0;
      repeat (3) @(posedge clk_sys);
      apb(1'b0, IDX_IRQ_STAT, 16'h0000);
      apb(1'b1, IDX_IRQ_MASK, 16'h0001);
      apb(1'b0, IDX_IRQ_MASK, 16'h0000);
      chk_w(rd, 16'h0001);
      chk_b(irq, 1'b0);
      lv <= '1;
      repeat (3) @(posedge clk_sys);
      chk_b(irq, 1'b1);
      apb(1'b0, IDX_IRQ_STAT, 16'h0000);
      chk_w(rd, 16'h0001);
      @(posedge clk_sys);
      chk_b(irq, 1'b0);
      // Mid-run reset while detecting with a custom threshold
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, IDX_FLAGS, 16'h0000);
      chk_w(rd, PART_ID);
      apb(1'b0, IDX_THRESH, 16'h0000);
      chk_w(rd, DEF_THRESH);
      // Back into detect so standby has flags to overwrite
      apb(1'b1, IDX_CONFIG, {9'h000, MODE_DETECT});
      repeat (2) @(posedge clk_sys);
      apb(1'b0, IDX_FLAGS, 16'h0000);
      chk_w(rd, 16'hFFFF);
      apb(1'b1, IDX_CONFIG, {9'h000, MODE_STANDBY});
      apb(1'b0, IDX_FLAGS, 16'h0000);
      chk_w(rd, PART_ID);
      test_done;
   end
endmodule : tdt_thresholds_tb
bind tdt_thresholds tdt_checker chk_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
